// ===== cbc_bridge_ctl.sv
// bridge control registers and per-socket control datapath
`default_nettype none
// Functional notes
// RULE_01 - bits 15..11 read zero, writes ignored
// RULE_02 - write posting enable, one per socket
// RULE_03 - post burst writes only, never unpostable ones
// RULE_04 - window 1 prefetchable bit, resets one
// RULE_05 - window 0 prefetchable bit, resets one
// RULE_06 - card irq to host or legacy irq
// RULE_07 - card reset follows its bit, resets asserted
// RULE_08 - host bus reset also drives card reset
// RULE_09 - master abort: silent or target abort plus serr
// RULE_10 - abort mode global, written through function 0
// RULE_11 - bit 4 reads zero, writes dropped
// RULE_12 - legacy video ranges forwarded when enabled
// RULE_13 - isa filter withholds upper 768 bytes per 1K
// RULE_14 - card system error forwarded when enabled
// RULE_15 - card parity errors reported when enabled
// RULE_16 - vendor id writable only when unlocked
// RULE_17 - subsystem_identifier writable when unlocked, per function
// RULE_18 - both ids loaded from serial memory
// RULE_19 - read-only ignores writes, reset restores defaults
module cbc_bridge_ctl (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              reset,
    // configuration access
    input  wire logic              cfg_wr,
    input  wire logic              cfg_rd,
    input  wire logic              cfg_func,
    input  wire logic [7:0]        cfg_addr,
    input  wire logic [3:0]        cfg_be,
    input  wire logic [31:0]       cfg_wdata,
    output logic      [31:0]       cfg_rdata,
    output logic                   cfg_rvalid,
    // identity control
    input  wire logic              subsystem_identifier_write_unlock,
    input  wire logic              serial_cfg_valid,
    input  wire logic              serial_cfg_func,
    input  wire logic [15:0]       serial_ssvid,
    input  wire logic [15:0]       serial_ssid,
    // host bus side
    input  wire logic              host_bus_reset_in,
    input  wire logic              host_serr_enable_in,
    output logic      [1:0]        host_target_abort_out,
    output logic      [1:0]        host_serr_out,
    output logic      [1:0]        irq_to_host_out,
    output logic      [1:0]        irq_to_legacy_out,
    // card write posting
    input  wire logic [1:0]        card_write_valid,
    input  wire logic [1:0]        card_write_burst,
    input  wire logic [1:0]        card_write_unpostable,
    output logic      [1:0]        card_write_post,
    // memory window prefetch
    input  wire logic [1:0]        mem_access_valid,
    input  wire logic [1:0]        mem_access_window,
    output logic      [1:0]        mem_prefetch_allow,
    // transaction address decode
    input  wire logic [1:0]        txn_valid,
    input  wire logic [1:0]        txn_is_io,
    input  wire logic [1:0][31:0]  txn_addr,
    output logic      [1:0]        txn_video_forward,
    output logic      [1:0]        txn_isa_withhold,
    // card socket events
    input  wire logic [1:0]        card_irq_in,
    input  wire logic [1:0]        card_master_abort_in,
    input  wire logic [1:0]        card_system_error_in,
    input  wire logic [1:0]        card_parity_detect_in,
    output logic      [1:0]        card_parity_error_out,
    output logic      [1:0]        card_reset_out
);
    // configuration dword match
    function automatic logic dw_hit(input logic [7:0] a,
                                    input logic [7:0] off);
        dw_hit = (a[7:2] == off[7:2]);
    endfunction

    // inclusive range check
    function automatic logic in_range(input logic [31:0] a,
                                      input logic [31:0] lo,
                                      input logic [31:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    logic        abort_mode_r;
    logic [31:0] cfg_rdata_r;
    logic        cfg_rvalid_r;
    logic [31:0] rdata_nxt;
    logic        hit_bctl;
    logic        hit_ids;
    logic        mode_we;
    logic [1:0][15:0] bctl_view;
    logic [1:0][15:0] ssvid_view;
    logic [1:0][15:0] ssid_view;

    assign hit_bctl = dw_hit(cfg_addr, cbc_pkg::OFF_BRIDGE_CONTROL);
    assign hit_ids  = dw_hit(cfg_addr, cbc_pkg::OFF_SUBSYS_VENDOR_ID);

    // global abort mode written only through function 0
    assign mode_we = cfg_wr && !cfg_func && hit_bctl && cfg_be[2]; // [RULE_10]

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            abort_mode_r <= cbc_pkg::BRIDGE_CONTROL_RESET[
                            cbc_pkg::BIT_ABORT_MODE];                // [RULE_19]
        end else if (mode_we) begin
            abort_mode_r <= cfg_wdata[16 + cbc_pkg::BIT_ABORT_MODE]; // [RULE_10]
        end
    end

    // per-function stores and socket datapaths
    for (genvar f = 0; f < cbc_pkg::NUM_FUNC; f++) begin : g_fn
        cbc_regs_if rif ();
        logic sel;
        logic [15:0] bctl;
        logic post_nxt;
        logic pref_nxt;
        logic video_hit;
        logic isa_hit;
        logic abort_rpt;
        logic serr_nxt;
        logic card_reset_out_nxt;

        assign sel = (cfg_func == f[0]);
        assign rif.bctl_we_lo  = cfg_wr && sel && hit_bctl && cfg_be[2];
        assign rif.bctl_we_hi  = cfg_wr && sel && hit_bctl && cfg_be[3];
        assign rif.ssvid_we_lo = cfg_wr && sel && hit_ids && cfg_be[0];
        assign rif.ssvid_we_hi = cfg_wr && sel && hit_ids && cfg_be[1];
        assign rif.ssid_we_lo  = cfg_wr && sel && hit_ids && cfg_be[2];
        assign rif.ssid_we_hi  = cfg_wr && sel && hit_ids && cfg_be[3];
        assign rif.wdata       = cfg_wdata;
        assign rif.unlock      = subsystem_identifier_write_unlock;      // [RULE_16]
        assign rif.load        = serial_cfg_valid &&
                                 (serial_cfg_func == f[0]);      // [RULE_18]
        assign rif.load_ssvid  = serial_ssvid;
        assign rif.load_ssid   = serial_ssid;

        cbc_func_regs u_regs (
            .clk   (clk),
            .reset (reset),
            .rif   (rif)
        );

        // global mode bit visible through both functions
        assign bctl = (rif.bctl & cbc_pkg::BRIDGE_CONTROL_WMASK) |
                      (16'(abort_mode_r) << cbc_pkg::BIT_ABORT_MODE);
        assign bctl_view[f]  = bctl;  // [RULE_01] [RULE_11]
        assign ssvid_view[f] = rif.ssvid;
        assign ssid_view[f]  = rif.ssid;

        // burst writes post only when enabled and postable
        assign post_nxt = card_write_valid[f] && card_write_burst[f] &&
                          !card_write_unpostable[f] &&
                          bctl[cbc_pkg::BIT_WRITE_POST];         // [RULE_02] [RULE_03]

        // window type selects prefetch permission
        assign pref_nxt = mem_access_valid[f] &&
            (mem_access_window[f] ? bctl[cbc_pkg::BIT_WIN1_PREFETCH]   // [RULE_04]
                                  : bctl[cbc_pkg::BIT_WIN0_PREFETCH]); // [RULE_05]

        // legacy video memory and io ranges
        assign video_hit = txn_valid[f] && bctl[cbc_pkg::BIT_VIDEO_FWD] &&
            (txn_is_io[f]
             ? (in_range(txn_addr[f], cbc_pkg::VIDEO_IO0_LO,
                         cbc_pkg::VIDEO_IO0_HI) ||
                in_range(txn_addr[f], cbc_pkg::VIDEO_IO1_LO,
                         cbc_pkg::VIDEO_IO1_HI))
             : in_range(txn_addr[f], cbc_pkg::VIDEO_MEM_LO,
                        cbc_pkg::VIDEO_MEM_HI));                 // [RULE_12]

        // upper 768 bytes of each 1K block below 64K
        assign isa_hit = txn_valid[f] && txn_is_io[f] &&
                         bctl[cbc_pkg::BIT_ISA_FILTER] &&
                         (txn_addr[f][31:16] == 16'h0000) &&
                         (txn_addr[f][9:8] != 2'h0);             // [RULE_13]

        // master abort reported only in report mode
        assign abort_rpt = card_master_abort_in[f] && abort_mode_r;  // [RULE_09]
        assign serr_nxt  = (abort_rpt && host_serr_enable_in) ||
                           (card_system_error_in[f] &&
                            bctl[cbc_pkg::BIT_CARD_SYSTEM_ERROR_IN_FWD]);       // [RULE_09] [RULE_14]

        // card reset from its bit or from host bus reset
        assign card_reset_out_nxt = bctl[cbc_pkg::BIT_CARD_RESET] ||
                          host_bus_reset_in;                     // [RULE_07] [RULE_08]

        always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
                card_write_post[f]       <= 1'b0;
                mem_prefetch_allow[f]    <= 1'b0;
                txn_video_forward[f]     <= 1'b0;
                txn_isa_withhold[f]      <= 1'b0;
                host_target_abort_out[f] <= 1'b0;
                host_serr_out[f]         <= 1'b0;
                irq_to_host_out[f]       <= 1'b0;
                irq_to_legacy_out[f]     <= 1'b0;
                card_parity_error_out[f] <= 1'b0;
                card_reset_out[f]        <= 1'b1;                // [RULE_07]
            end else begin
                card_write_post[f]       <= post_nxt;
                mem_prefetch_allow[f]    <= pref_nxt;
                txn_video_forward[f]     <= video_hit;
                txn_isa_withhold[f]      <= isa_hit;
                host_target_abort_out[f] <= abort_rpt;           // [RULE_09]
                host_serr_out[f]         <= serr_nxt;
                irq_to_host_out[f]       <= card_irq_in[f] &&
                    !bctl[cbc_pkg::BIT_IRQ_ROUTE];               // [RULE_06]
                irq_to_legacy_out[f]     <= card_irq_in[f] &&
                    bctl[cbc_pkg::BIT_IRQ_ROUTE];                // [RULE_06]
                card_parity_error_out[f] <= card_parity_detect_in[f] &&
                    bctl[cbc_pkg::BIT_PARITY_RESP];              // [RULE_15]
                card_reset_out[f]        <= card_reset_out_nxt;            // [RULE_08]
            end
        end
    end

    // read data: unmapped dwords and other bytes read zero
    assign rdata_nxt =
        hit_bctl ? {bctl_view[cfg_func], 16'h0000} :
        hit_ids  ? {ssid_view[cfg_func], ssvid_view[cfg_func]} :
                   32'h00000000;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cfg_rdata_r  <= 32'h00000000;
            cfg_rvalid_r <= 1'b0;
        end else begin
            cfg_rvalid_r <= cfg_rd;
            if (cfg_rd) begin
                cfg_rdata_r <= rdata_nxt;
            end
        end
    end

    assign cfg_rdata  = cfg_rdata_r;
    assign cfg_rvalid = cfg_rvalid_r;
endmodule // cbc_bridge_ctl
`default_nettype wire

// ===== cbc_pkg.sv
// constants for the bridge control and subsystem identity registers
`default_nettype none
package cbc_pkg;
    // configuration offsets (byte addresses)
    localparam logic [7:0]  OFF_BRIDGE_CONTROL     = 8'h3E;
    localparam logic [7:0]  OFF_SUBSYS_VENDOR_ID   = 8'h40;
    localparam logic [7:0]  OFF_SUBSYS_ID          = 8'h42;
    // bridge control field positions
    localparam int          BIT_PARITY_RESP        = 0;
    localparam int          BIT_CARD_SYSTEM_ERROR_IN_FWD          = 1;
    localparam int          BIT_ISA_FILTER         = 2;
    localparam int          BIT_VIDEO_FWD          = 3;
    localparam int          BIT_ABORT_MODE         = 5;
    localparam int          BIT_CARD_RESET         = 6;
    localparam int          BIT_IRQ_ROUTE          = 7;
    localparam int          BIT_WIN0_PREFETCH      = 8;
    localparam int          BIT_WIN1_PREFETCH      = 9;
    localparam int          BIT_WRITE_POST         = 10;
    // reset values and writable masks
    localparam logic [15:0] BRIDGE_CONTROL_RESET   = 16'h0340;
    localparam logic [15:0] BRIDGE_CONTROL_WMASK   = 16'h07EF;
    localparam logic [15:0] BRIDGE_LOCAL_WMASK     = 16'h07CF;
    localparam logic [15:0] SUBSYS_VENDOR_RESET    = 16'h0000;
    localparam logic [15:0] SUBSYS_ID_RESET        = 16'h0000;
    // legacy address windows
    localparam logic [31:0] VIDEO_MEM_LO           = 32'h000A0000;
    localparam logic [31:0] VIDEO_MEM_HI           = 32'h000BFFFF;
    localparam logic [31:0] VIDEO_IO0_LO           = 32'h000003B0;
    localparam logic [31:0] VIDEO_IO0_HI           = 32'h000003BB;
    localparam logic [31:0] VIDEO_IO1_LO           = 32'h000003C0;
    localparam logic [31:0] VIDEO_IO1_HI           = 32'h000003DF;
    localparam int          NUM_FUNC               = 2;
endpackage : cbc_pkg
`default_nettype wire

// ===== cbc_regs_if.sv
// carrier between the register front end and one function's store
`default_nettype none
interface cbc_regs_if;
    logic        bctl_we_lo;
    logic        bctl_we_hi;
    logic        ssvid_we_lo;
    logic        ssvid_we_hi;
    logic        ssid_we_lo;
    logic        ssid_we_hi;
    logic [31:0] wdata;
    logic        unlock;
    logic        load;
    logic [15:0] load_ssvid;
    logic [15:0] load_ssid;
    logic [15:0] bctl;
    logic [15:0] ssvid;
    logic [15:0] ssid;
    modport store (input bctl_we_lo, bctl_we_hi, ssvid_we_lo, ssvid_we_hi,
                   input ssid_we_lo, ssid_we_hi, wdata, unlock, load,
                   input load_ssvid, load_ssid,
                   output bctl, ssvid, ssid);
    modport front (output bctl_we_lo, bctl_we_hi, ssvid_we_lo, ssvid_we_hi,
                   output ssid_we_lo, ssid_we_hi, wdata, unlock, load,
                   output load_ssvid, load_ssid,
                   input bctl, ssvid, ssid);
endinterface : cbc_regs_if
`default_nettype wire

// ===== cbc_func_regs.sv
// per-function store of bridge control and subsystem identity
`default_nettype none
module cbc_func_regs (
    // clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // register carrier
    cbc_regs_if.store rif
);
    logic [15:0] bctl_r;
    logic [15:0] ssvid_r;
    logic [15:0] ssid_r;
    logic [15:0] bctl_nxt;
    logic [15:0] ssvid_nxt;
    logic [15:0] ssid_nxt;
    logic        id_wr_ok;

    // reserved and global bits never stored here
    assign bctl_nxt[7:0]  = rif.bctl_we_lo
        ? (rif.wdata[23:16] & cbc_pkg::BRIDGE_LOCAL_WMASK[7:0])
        : bctl_r[7:0];                                   // [RULE_11]
    assign bctl_nxt[15:8] = rif.bctl_we_hi
        ? (rif.wdata[31:24] & cbc_pkg::BRIDGE_LOCAL_WMASK[15:8])
        : bctl_r[15:8];                                  // [RULE_01]

    // identity writable only while unlocked; serial load wins
    assign id_wr_ok = rif.unlock;                        // [RULE_16] [RULE_17]
    assign ssvid_nxt = rif.load ? rif.load_ssvid :       // [RULE_18]
        {(id_wr_ok && rif.ssvid_we_hi) ? rif.wdata[15:8] : ssvid_r[15:8],
         (id_wr_ok && rif.ssvid_we_lo) ? rif.wdata[7:0]  : ssvid_r[7:0]};
    assign ssid_nxt = rif.load ? rif.load_ssid :         // [RULE_18]
        {(id_wr_ok && rif.ssid_we_hi) ? rif.wdata[31:24] : ssid_r[15:8],
         (id_wr_ok && rif.ssid_we_lo) ? rif.wdata[23:16] : ssid_r[7:0]};

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin                                 // [RULE_19]
            bctl_r  <= cbc_pkg::BRIDGE_CONTROL_RESET &
                       cbc_pkg::BRIDGE_LOCAL_WMASK;
            ssvid_r <= cbc_pkg::SUBSYS_VENDOR_RESET;
            ssid_r  <= cbc_pkg::SUBSYS_ID_RESET;
        end else begin
            bctl_r  <= bctl_nxt;
            ssvid_r <= ssvid_nxt;
            ssid_r  <= ssid_nxt;
        end
    end

    assign rif.bctl  = bctl_r;
    assign rif.ssvid = ssvid_r;
    assign rif.ssid  = ssid_r;
endmodule // cbc_func_regs
`default_nettype wire

// ===== cbc_card_model.sv
// card socket model raising event lines on bench command
`default_nettype none
module cbc_card_model (
    // command from the bench: irq, abort, system error, parity
    input  wire logic [3:0] ev,
    // card socket event lines, same event on both sockets
    output logic      [1:0] card_irq_in,
    output logic      [1:0] card_master_abort_in,
    output logic      [1:0] card_system_error_in,
    output logic      [1:0] card_parity_detect_in
);
    timeunit 1ns;
    timeprecision 100ps;
    assign card_irq_in           = {2{ev[0]}};
    assign card_master_abort_in  = {2{ev[1]}};
    assign card_system_error_in  = {2{ev[2]}};
    assign card_parity_detect_in = {2{ev[3]}};
endmodule // cbc_card_model
`default_nettype wire

// ===== cbc_bridge_ctl_sva.sv
// port assertions for the bridge control block
`default_nettype none
module cbc_bridge_ctl_sva (
    // clock and reset
    input wire logic             clk,
    input wire logic             reset,
    // configuration access
    input wire logic [7:0]       cfg_addr,
    input wire logic [31:0]      cfg_rdata,
    input wire logic             cfg_rvalid,
    // host side
    input wire logic             host_bus_reset_in,
    input wire logic [1:0]       host_target_abort_out,
    input wire logic [1:0]       host_serr_out,
    input wire logic [1:0]       irq_to_host_out,
    input wire logic [1:0]       irq_to_legacy_out,
    // card side
    input wire logic [1:0]       card_write_valid,
    input wire logic [1:0]       card_write_burst,
    input wire logic [1:0]       card_write_unpostable,
    input wire logic [1:0]       card_write_post,
    input wire logic [1:0]       txn_is_io,
    input wire logic [1:0][31:0] txn_addr,
    input wire logic [1:0]       txn_isa_withhold,
    input wire logic [1:0]       card_irq_in,
    input wire logic [1:0]       card_master_abort_in,
    input wire logic [1:0]       card_system_error_in,
    input wire logic [1:0]       card_parity_detect_in,
    input wire logic [1:0]       card_parity_error_out,
    input wire logic [1:0]       card_reset_out
);
    timeunit 1ns;
    timeprecision 100ps;
    wire logic [1:0] isa_hit;
    wire logic [1:0] post_ok;
    assign isa_hit[0] = txn_addr[0][31:16] == 16'h0000 && |txn_addr[0][9:8];
    assign isa_hit[1] = txn_addr[1][31:16] == 16'h0000 && |txn_addr[1][9:8];
    assign post_ok = card_write_valid & card_write_burst
                     & ~card_write_unpostable;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    AST_CARD_RESET_OUT_HOST: assert property ($past(host_bus_reset_in)
        |-> card_reset_out == 2'b11) else $error("card reset not forced");
    AST_POST_BURST: assert property (
        (card_write_post & ~$past(post_ok)) == 2'b00)
        else $error("non-burst write posted");
    AST_IRQ_ROUTE: assert property ((irq_to_host_out & irq_to_legacy_out)
        == 2'b00 && ((irq_to_host_out | irq_to_legacy_out)
        & ~$past(card_irq_in)) == 2'b00) else $error("irq misrouted");
    AST_PERR_CAUSE: assert property (
        (card_parity_error_out & ~$past(card_parity_detect_in)) == 2'b00)
        else $error("parity error without cause");
    AST_RSVD_ZERO: assert property (cfg_rvalid
        && ($past(cfg_addr) & 8'hFC) == 8'h3C
        |-> cfg_rdata[31:27] == 5'h00 && !cfg_rdata[20])
        else $error("reserved control bits read nonzero");
    AST_ABORT_CAUSE: assert property (
        (host_target_abort_out & ~$past(card_master_abort_in)) == 2'b00)
        else $error("target abort without master abort");
    AST_SERR_CAUSE: assert property ((host_serr_out
        & ~$past(card_system_error_in | card_master_abort_in)) == 2'b00)
        else $error("system error without cause");
    AST_ISA_RANGE: assert property (
        (txn_isa_withhold & ~$past(txn_is_io & isa_hit)) == 2'b00)
        else $error("isa withhold outside range");
    cover property (cfg_rvalid);
    cover property (|host_target_abort_out);
    cover property (|txn_isa_withhold);
endmodule // cbc_bridge_ctl_sva
bind cbc_bridge_ctl cbc_bridge_ctl_sva cbc_bridge_ctl_sva_inst (.*);
`default_nettype wire

// ===== cbc_bridge_ctl_tb_top.sv
// self-checking bench for the bridge control block
`default_nettype none
module cbc_bridge_ctl_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, reset = 1'b1, cfg_wr = 1'b0, cfg_rd = 1'b0;
    logic cfg_func = 1'b0, subsystem_identifier_write_unlock = 1'b0;
    logic serial_cfg_valid = 1'b0, serial_cfg_func = 1'b0;
    logic host_bus_reset_in = 1'b0, host_serr_enable_in = 1'b0, cfg_rvalid;
    logic [7:0] cfg_addr = 8'h00;
    logic [3:0] cfg_be = 4'h0, ev = 4'h0;
    logic [31:0] cfg_wdata = 32'h00000000, cfg_rdata;
    logic [15:0] serial_ssvid = 16'h0000, serial_ssid = 16'h0000;
    logic [1:0] card_write_valid = '0, card_write_burst = '0;
    logic [1:0] card_write_unpostable = '0, mem_access_valid = '0;
    logic [1:0] mem_access_window = '0, txn_valid = '0, txn_is_io = '0;
    logic [1:0][31:0] txn_addr = '0;
    logic [1:0] host_target_abort_out, host_serr_out, irq_to_host_out;
    logic [1:0] irq_to_legacy_out, card_write_post, mem_prefetch_allow;
    logic [1:0] txn_video_forward, txn_isa_withhold, card_irq_in;
    logic [1:0] card_master_abort_in, card_system_error_in;
    logic [1:0] card_parity_detect_in, card_parity_error_out, card_reset_out;
    int errors = 0, n_checks = 0;
    cbc_bridge_ctl cbc_bridge_ctl_inst (.*);
    cbc_card_model cbc_card_model_inst (
        .ev                    (ev),
        .card_irq_in           (card_irq_in),
        .card_master_abort_in  (card_master_abort_in),
        .card_system_error_in  (card_system_error_in),
        .card_parity_detect_in (card_parity_detect_in));
    always #2 clk = ~clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("FAIL t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic f, input logic [7:0] a,
                      input logic [3:0] be, input logic [31:0] d);
        @(posedge clk) #1;
        cfg_wr = 1'b1;
        cfg_func = f;
        cfg_addr = a;
        cfg_be = be;
        cfg_wdata = d;
        @(posedge clk) #1;
        cfg_wr = 1'b0;
    endtask
    task automatic rd(input logic f, input logic [7:0] a,
                      input logic [31:0] e);
        @(posedge clk) #1;
        cfg_rd = 1'b1;
        cfg_func = f;
        cfg_addr = a;
        @(posedge clk) #1;
        cfg_rd = 1'b0;
        chk(cfg_rvalid, 1);
        chk(cfg_rdata, e);
    endtask
    task automatic dp(input logic on);
        logic [1:0] e;
        e = {on, on};
        @(posedge clk) #1;
        card_write_valid = 2'b11;
        card_write_burst = 2'b11;
        card_write_unpostable = 2'b00;
        mem_access_valid = 2'b11;
        mem_access_window = 2'b10;
        txn_valid = 2'b11;
        txn_is_io = 2'b11;
        txn_addr = {32'h00000100, 32'h000003C0};
        ev = 4'hF;
        @(posedge clk) #1;
        chk(card_write_post, e);
        chk(mem_prefetch_allow, e);
        chk(irq_to_legacy_out, e);
        chk(irq_to_host_out, e ^ 2'b11);
        chk(host_target_abort_out, e);
        chk(host_serr_out, e);
        chk(card_parity_error_out, e);
        chk(txn_video_forward, {1'b0, on});
        chk(txn_isa_withhold, e);
        chk(card_reset_out, e);
        card_write_unpostable = 2'b11;
        txn_is_io = 2'b00;
        txn_addr = {32'h000C0000, 32'h000A0000};
        ev = 4'h0;
        @(posedge clk) #1;
        chk(card_write_post, 2'b00);
        chk(txn_video_forward, {1'b0, on});
        chk(txn_isa_withhold, 2'b00);
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #4000;
        errors++;
        conclude();
    end
    initial begin
        repeat (12) @(posedge clk);
        #1 reset = 1'b0;
        chk(card_reset_out, 2'b11);
        rd(0, 8'h3C, 32'h03400000);
        rd(1, 8'h3E, 32'h03400000);
        wr(1, 8'h3C, 4'hF, 32'hFFFFFFFF);
        rd(1, 8'h3C, 32'h07CF0000);
        wr(0, 8'h3C, 4'hF, 32'hFFFFFFFF);
        rd(1, 8'h3C, 32'h07EF0000);
        wr(0, 8'h3C, 4'h1, 32'h00000000);
        rd(1, 8'h3C, 32'h07EF0000);
        dp(1);
        wr(0, 8'h3C, 4'hF, 32'h00000000);
        rd(0, 8'h3C, 32'h00000000);
        rd(1, 8'h3C, 32'h07CF0000);
        wr(1, 8'h3C, 4'hF, 32'h00000000);
        host_serr_enable_in = 1'b1;
        dp(0);
        wr(0, 8'h3C, 4'h4, 32'h00200000);
        ev = 4'h2;
        @(posedge clk) #1;
        chk(host_target_abort_out, 2'b11);
        chk(host_serr_out, 2'b11);
        ev = 4'h0;
        host_bus_reset_in = 1'b1;
        @(posedge clk) #1;
        chk(card_reset_out, 2'b11);
        host_bus_reset_in = 1'b0;
        wr(1, 8'h40, 4'hF, 32'h12345678);
        rd(1, 8'h40, 32'h00000000);
        subsystem_identifier_write_unlock = 1'b1;
        wr(1, 8'h40, 4'hF, 32'h12345678);
        rd(1, 8'h40, 32'h12345678);
        rd(0, 8'h40, 32'h00000000);
        serial_cfg_valid = 1'b1;
        serial_ssvid = 16'hA5A5;
        serial_ssid = 16'h5A5A;
        @(posedge clk) #1;
        serial_cfg_valid = 1'b0;
        rd(0, 8'h40, 32'h5A5AA5A5);
        rd(0, 8'h44, 32'h00000000);
        reset = 1'b1;
        @(posedge clk) #1;
        reset = 1'b0;
        rd(1, 8'h40, 32'h00000000);
        rd(1, 8'h3C, 32'h03400000);
        conclude();
    end
endmodule // cbc_bridge_ctl_tb_top
`default_nettype wire
